// [hdl/mies_defines.svh]
// Constants for the instruction execution block: encodings, reset values and sizes.
`ifndef MIES_DEFINES_SVH
`define MIES_DEFINES_SVH

`define MIES_OP_IDLE        13'h0000
`define MIES_OP_OPTION      13'h0002
`define MIES_OP_SLEEP       13'h0003
`define MIES_OP_RETURN      13'h000c
`define MIES_OP_IRQ_RETURN  13'h000d

`define MIES_LIT_RET        5'h1a
`define MIES_LIT_SUB        5'h1b
`define MIES_LIT_XOR        5'h1c
`define MIES_LIT_OPC_MSB    12
`define MIES_LIT_OPC_LSB    8

`define MIES_REG_RL         6'h14
`define MIES_REG_RR         6'h15
`define MIES_REG_SBC        6'h16
`define MIES_REG_SUB        6'h17
`define MIES_REG_SWAP       6'h18
`define MIES_REG_XOR        6'h19
`define MIES_REG_OPC_MSB    12
`define MIES_REG_OPC_LSB    7
`define MIES_DEST_BIT       6
`define MIES_FADDR_MSB      5
`define MIES_LIT_MSB        7

`define MIES_PC_RST         10'h000
`define MIES_WREG_RST       8'h00
`define MIES_OPTION_RST     8'hff
`define MIES_FLAGS_RST      6'h18
`define MIES_STACK_DEPTH    5
`define MIES_SP_LAST        3'h4

`endif

// [hdl/mies_pkg.sv]
// Types shared by the instruction execution block and its surroundings.
package mies_pkg;

   typedef enum logic [1:0] {
      mies_run,
      mies_flush,
      mies_sleep
   } mies_state_t;

   typedef struct packed {
      logic       global_irq_enable;
      logic       watchdog_expiry_flag;
      logic       sleep_entry_flag;
      logic       zero;
      logic       half_carry_flag;
      logic       carry;
   } mies_flags_t;

   typedef struct packed {
      logic       we;
      logic [5:0] addr;
      logic [7:0] data;
   } mies_fwr_t;

endpackage

// [hdl/mies_exec.sv]
// Execution unit for the no-op, setup, return, rotate, sleep, subtract, swap and xor instructions.
`timescale 1ns/1ps
`include "mies_defines.svh"

// Behaviour
// (RULE1) Setup op copies working register, flags untouched.
// (RULE2) Irq return pops pc, sets irq enable.
// (RULE3) Literal return loads literal, pops pc, two cycles.
// (RULE4) Plain return pops pc, two cycles, flags kept.
// (RULE5) Rotate left through carry.
// (RULE6) Rotate right through carry.
// (RULE7) Destination bit picks working or file register.
// (RULE8) Sleep clears watchdog counter and prescaler.
// (RULE9) Sleep sets expiry flag, clears entry flag, halts.
// (RULE10) Borrow subtract: file plus inverted working plus carry.
// (RULE11) File minus working, flags, destination honoured.
// (RULE12) Literal minus working into working register.
// (RULE13) Nibble exchange, flags untouched.
// (RULE14) Register xor, destination routed, zero only.
// (RULE15) Literal xor into working register, zero only.
// (RULE16) Returns discard prefetched word with idle cycle.
// (RULE17) Idle op changes nothing but pc increment.
module mies_exec (
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic                  instr_valid,
   input  wire logic [12:0]           instr,
   input  wire logic [7:0]            file_rdata,
   input  wire logic                  wake_req,
   input  wire logic                  stack_push,
   input  wire logic [9:0]            stack_push_addr,
   output logic [9:0]                 pc,
   output logic                       instr_ready,
   output logic [5:0]                 file_raddr,
   output mies_pkg::mies_fwr_t        file_wr,
   output logic [7:0]                 working_register,
   output mies_pkg::mies_flags_t      flags,
   output logic [7:0]                 option_setup,
   output logic                       watchdog_clear,
   output logic                       sleep_mode,
   output logic                       unknown_op
);

   mies_pkg::mies_state_t  state;
   mies_pkg::mies_state_t  next_state;

   logic [9:0]             next_pc;
   logic [7:0]             next_working_register;
   mies_pkg::mies_flags_t  next_flags;
   logic [7:0]             next_option_setup;
   mies_pkg::mies_fwr_t    next_file_wr;
   logic                   next_watchdog_clear;
   logic                   next_unknown_op;

   // Five entries used as a ring: a sixth push silently overwrites the oldest one.
   logic [9:0]             stack [0:`MIES_STACK_DEPTH-1];
   logic [9:0]             next_stack [0:`MIES_STACK_DEPTH-1];
   logic [2:0]             sp;
   logic [2:0]             next_sp;
   logic [2:0]             pop_index;

   logic                   take;
   logic                   dest;
   logic [7:0]             lit;
   logic [4:0]             lit_opc;
   logic [5:0]             reg_opc;

   logic [7:0]             sub_a;
   logic                   sub_cin;
   logic [8:0]             sub_sum;
   logic [4:0]             sub_low;

   logic [7:0]             result;
   logic                   result_valid;

   // The fetch side must hold the word steady while this is low.
   assign instr_ready = (state == mies_pkg::mies_run);
   // A word and a push may meet in one cycle: the take wins and the push is lost.
   assign take        = instr_ready & instr_valid;
   assign sleep_mode  = (state == mies_pkg::mies_sleep);
   // Field slices are fixed wiring; the opcode compares below decide which of them count.
   assign file_raddr  = instr[`MIES_FADDR_MSB:0];
   assign dest        = instr[`MIES_DEST_BIT];
   assign lit         = instr[`MIES_LIT_MSB:0];
   assign lit_opc     = instr[`MIES_LIT_OPC_MSB:`MIES_LIT_OPC_LSB];
   assign reg_opc     = instr[`MIES_REG_OPC_MSB:`MIES_REG_OPC_LSB];
   // The pointer names the next free entry, so a pop reads the one below it, wrapping at zero.
   assign pop_index   = (sp == 3'h0) ? `MIES_SP_LAST : sp - 3'h1;

   // One shared adder serves all three subtract forms; a minus b is a plus not b plus one.
   // Carry reads 1 when no borrow occurred, and the low-nibble sum gives the half carry.
   always_comb
   begin
      sub_a   = file_rdata;
      sub_cin = 1'b1;
      if (lit_opc == `MIES_LIT_SUB)
      begin
         sub_a = lit;                                                // RULE12
      end
      else if (reg_opc == `MIES_REG_SBC)
      begin
         // The borrow form feeds the current carry in place of the fixed one.
         sub_cin = flags.carry;                                      // RULE10
      end
      sub_sum = {1'b0, sub_a} + {1'b0, ~working_register} + {8'h00, sub_cin};
      sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~working_register[3:0]} + {4'h0, sub_cin};
   end

   // Next values of every register of the unit; the clocked process below only stores them.
   always_comb
   begin
      next_state            = state;
      next_pc               = pc;
      next_working_register = working_register;
      next_flags            = flags;
      next_option_setup     = option_setup;
      next_file_wr          = '0;
      next_watchdog_clear   = 1'b0;
      next_unknown_op       = 1'b0;
      next_sp               = sp;
      result                = 8'h00;
      result_valid          = 1'b0;
      for (int i = 0; i < `MIES_STACK_DEPTH; i++)
      begin
         next_stack[i] = stack[i];
      end

      case (state)
         mies_pkg::mies_run:
         begin
            if (take)
            begin
               next_pc = pc + 10'h001;                               // RULE17
               if (instr == `MIES_OP_IDLE)
               begin
                  // The idle word takes the plain increment and nothing else.
                  next_pc = pc + 10'h001;                            // RULE17
               end
               else if (instr == `MIES_OP_OPTION)
               begin
                  // Flags keep their default here, so the setup copy leaves them alone.
                  next_option_setup = working_register;              // RULE1
               end
               else if (instr == `MIES_OP_SLEEP)
               begin
                  next_watchdog_clear             = 1'b1;            // RULE8
                  next_flags.watchdog_expiry_flag = 1'b1;            // RULE9
                  next_flags.sleep_entry_flag     = 1'b0;            // RULE9
                  // The pc already points past the sleep word, so a wake resumes at the next one.
                  next_state                      = mies_pkg::mies_sleep;
               end
               else if (instr == `MIES_OP_RETURN || instr == `MIES_OP_IRQ_RETURN
                        || lit_opc == `MIES_LIT_RET)
               begin
                  // The popped address loads now; the flush state then drops the word already fetched.
                  next_pc    = stack[pop_index];                     // RULE4
                  next_sp    = pop_index;
                  next_state = mies_pkg::mies_flush;                 // RULE16
                  if (instr == `MIES_OP_IRQ_RETURN)
                  begin
                     next_flags.global_irq_enable = 1'b1;            // RULE2
                  end
                  else if (lit_opc == `MIES_LIT_RET)
                  begin
                     next_working_register = lit;                    // RULE3
                  end
               end
               else if (lit_opc == `MIES_LIT_SUB)
               begin
                  next_working_register      = sub_sum[7:0];         // RULE12
                  next_flags.carry           = sub_sum[8];
                  next_flags.half_carry_flag = sub_low[4];
                  next_flags.zero            = (sub_sum[7:0] == 8'h00);
               end
               else if (lit_opc == `MIES_LIT_XOR)
               begin
                  next_working_register = working_register ^ lit;    // RULE15
                  next_flags.zero       = ((working_register ^ lit) == 8'h00);
               end
               else if (reg_opc == `MIES_REG_RL)
               begin
                  result           = {file_rdata[6:0], flags.carry}; // RULE5
                  next_flags.carry = file_rdata[7];
                  result_valid     = 1'b1;
               end
               else if (reg_opc == `MIES_REG_RR)
               begin
                  result           = {flags.carry, file_rdata[7:1]}; // RULE6
                  next_flags.carry = file_rdata[0];
                  result_valid     = 1'b1;
               end
               else if (reg_opc == `MIES_REG_SBC || reg_opc == `MIES_REG_SUB)
               begin
                  result                     = sub_sum[7:0];         // RULE10 RULE11
                  next_flags.carry           = sub_sum[8];
                  next_flags.half_carry_flag = sub_low[4];
                  next_flags.zero            = (sub_sum[7:0] == 8'h00);
                  result_valid               = 1'b1;
               end
               else if (reg_opc == `MIES_REG_SWAP)
               begin
                  result       = {file_rdata[3:0], file_rdata[7:4]}; // RULE13
                  result_valid = 1'b1;
               end
               else if (reg_opc == `MIES_REG_XOR)
               begin
                  result          = working_register ^ file_rdata;   // RULE14
                  next_flags.zero = (result == 8'h00);
                  result_valid    = 1'b1;
               end
               else
               begin
                  // Words outside this subset belong to other units; here they advance pc and raise unknown_op.
                  next_unknown_op = 1'b1;
               end

               // File writes leave through a register and land one cycle after the take, so the
               // fetch side must not read the same register back in the very next cycle.
               if (result_valid)
               begin
                  if (dest)
                  begin
                     next_file_wr.we   = 1'b1;                       // RULE7
                     next_file_wr.addr = file_raddr;
                     next_file_wr.data = result;
                  end
                  else
                  begin
                     next_working_register = result;                 // RULE7
                  end
               end
            end
            else if (stack_push)
            begin
               // Calls are decoded elsewhere and only stall-free cycles may push.
               next_stack[sp] = stack_push_addr;
               next_sp        = (sp == `MIES_SP_LAST) ? 3'h0 : sp + 3'h1;
            end
         end

         mies_pkg::mies_flush:
         begin
            // The word fetched alongside the return is dropped here.
            next_state = mies_pkg::mies_run;                         // RULE16
         end

         mies_pkg::mies_sleep:
         begin
            // Sleep ignores both words and pushes; only wake_req leaves it.
            if (wake_req)
            begin
               next_state = mies_pkg::mies_run;                      // RULE9
            end
         end

         default:
         begin
            // An unused state code falls back to run rather than locking the unit up.
            next_state = mies_pkg::mies_run;
         end
      endcase
   end

   // Registers only; every decision is taken in the process above.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state                      <= mies_pkg::mies_run;
         pc                         <= `MIES_PC_RST;
         working_register           <= `MIES_WREG_RST;
         // Both power status flags come up set, as after a cold start.
         flags                      <= `MIES_FLAGS_RST;
         option_setup               <= `MIES_OPTION_RST;
         file_wr                    <= '0;
         watchdog_clear             <= 1'b0;
         unknown_op                 <= 1'b0;
         sp                         <= 3'h0;

         for (int i = 0; i < `MIES_STACK_DEPTH; i++)
         begin
            stack[i] <= `MIES_PC_RST;
         end
      end
      else
      begin
         state            <= next_state;
         pc               <= next_pc;
         working_register <= next_working_register;
         flags            <= next_flags;
         option_setup     <= next_option_setup;
         file_wr          <= next_file_wr;
         watchdog_clear   <= next_watchdog_clear;
         unknown_op       <= next_unknown_op;
         sp               <= next_sp;

         for (int i = 0; i < `MIES_STACK_DEPTH; i++)
         begin
            stack[i] <= next_stack[i];
         end
      end
   end

endmodule

// [verif/mies_exec_sva.sv]
// Property checker for the execution unit, bound to its ports.
`timescale 1ns/1ps
`include "mies_defines.svh"
module mies_chk (
   input wire logic                  mclk,
   input wire logic                  rst_b,
   input wire logic                  instr_valid,
   input wire logic [12:0]           instr,
   input wire logic [7:0]            file_rdata,
   input wire logic                  wake_req,
   input wire logic [9:0]            pc,
   input wire logic                  instr_ready,
   input wire mies_pkg::mies_fwr_t   file_wr,
   input wire logic [7:0]            working_register,
   input wire mies_pkg::mies_flags_t flags,
   input wire logic [7:0]            option_setup,
   input wire logic                  watchdog_clear,
   input wire logic                  sleep_mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire logic       tk = instr_valid && instr_ready;
   wire logic [7:0] lit = instr[7:0];
   wire logic [7:0] swp = {file_rdata[3:0], file_rdata[7:4]};
   sequence s_ret;
      tk && (instr == `MIES_OP_RETURN || instr == `MIES_OP_IRQ_RETURN || instr[12:8] == `MIES_LIT_RET);
   endsequence
   sequence s_flush;
      !instr_ready ##1 instr_ready;
   endsequence
   a_ret_flush: assert property (s_ret |=> s_flush)
      else $error("return without one dead cycle");
   a_irq_gie: assert property (tk && instr == `MIES_OP_IRQ_RETURN |=> flags.global_irq_enable)
      else $error("irq return left enable clear");
   a_setup_copy: assert property (tk && instr == `MIES_OP_OPTION |=>
      option_setup == $past(working_register) && flags == $past(flags)) else $error("setup copy wrong");
   a_lit_ret: assert property (tk && instr[12:8] == `MIES_LIT_RET |=>
      working_register == $past(lit) && flags == $past(flags)) else $error("literal return wrong");
   a_sleep_entry: assert property (tk && instr == `MIES_OP_SLEEP |=> watchdog_clear && sleep_mode &&
      flags.watchdog_expiry_flag && !flags.sleep_entry_flag ##1 !watchdog_clear) else $error("sleep entry wrong");
   a_sleep_hold: assert property (sleep_mode && !wake_req |=> sleep_mode && !instr_ready)
      else $error("left sleep without wake");
   a_xor_lit: assert property (tk && instr[12:8] == `MIES_LIT_XOR |=>
      working_register == ($past(working_register) ^ $past(lit)) && flags.zero == (working_register == 8'h00)
      && flags.carry == $past(flags.carry)) else $error("literal xor wrong");
   a_idle_keep: assert property (tk && instr == `MIES_OP_IDLE |=> pc == $past(pc) + 10'h001 &&
      working_register == $past(working_register) && flags == $past(flags) && !file_wr.we) else $error("idle changed state");
   a_swap_file: assert property (tk && instr[12:7] == `MIES_REG_SWAP && instr[6] |=>
      file_wr.we && file_wr.data == $past(swp)) else $error("swap write wrong");
   a_sub_lit: assert property (tk && instr[12:8] == `MIES_LIT_SUB |=>
      working_register == $past(lit) - $past(working_register)) else $error("literal subtract wrong");
endmodule

bind mies_exec mies_chk u_chk (.mclk(mclk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
   .file_rdata(file_rdata), .wake_req(wake_req), .pc(pc), .instr_ready(instr_ready), .file_wr(file_wr),
   .working_register(working_register), .flags(flags), .option_setup(option_setup),
   .watchdog_clear(watchdog_clear), .sleep_mode(sleep_mode));

// [verif/mies_file_model.sv]
// Data file register model: combinational read, write on the registered strobe.
`timescale 1ns/1ps
module mies_file_model (
   input wire logic                mclk,
   input wire logic [5:0]          file_raddr,
   input wire mies_pkg::mies_fwr_t file_wr,
   output logic [7:0]              file_rdata
);
   logic [7:0] mem [64];
   initial
   begin
      for (int i = 0; i < 64; i++)
         mem[i] = 8'h9c ^ 8'(i * 37);
   end
   assign file_rdata = mem[file_raddr];
   always @(posedge mclk)
   begin
      if (file_wr.we)
         mem[file_wr.addr] <= file_wr.data;
   end
endmodule

// [verif/test_mies_exec.sv]
// Self-checking bench: each instruction is run against a reference of the state it must leave.
`timescale 1ns/1ps
`include "mies_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module test_mies_exec;
   logic                  mclk = 1'b0;
   logic                  rst_b = 1'b0;
   logic                  instr_valid = 1'b0;
   logic [12:0]           instr = 13'h0000;
   logic                  wake_req = 1'b0;
   logic                  stack_push = 1'b0;
   logic [9:0]            stack_push_addr = 10'h000;
   logic [7:0]            file_rdata;
   logic [5:0]            file_raddr;
   logic [9:0]            pc;
   logic                  instr_ready;
   mies_pkg::mies_fwr_t   file_wr;
   logic [7:0]            working_register;
   mies_pkg::mies_flags_t flags;
   logic [7:0]            option_setup;
   logic                  watchdog_clear;
   logic                  sleep_mode;
   logic                  unknown_op;
   int                    fail_count = 0;
   int                    checked = 0;
   int                    cyc = 0;
   mies_pkg::mies_flags_t ef = `MIES_FLAGS_RST;
   logic [7:0]            ew = `MIES_WREG_RST;
   logic [7:0]            eo = `MIES_OPTION_RST;
   logic [9:0]            ep = `MIES_PC_RST;
   logic [9:0]            stk [$];
   mies_exec uut (.mclk(mclk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
      .wake_req(wake_req), .stack_push(stack_push), .stack_push_addr(stack_push_addr), .pc(pc),
      .instr_ready(instr_ready), .file_raddr(file_raddr), .file_wr(file_wr), .working_register(working_register),
      .flags(flags), .option_setup(option_setup), .watchdog_clear(watchdog_clear), .sleep_mode(sleep_mode),
      .unknown_op(unknown_op));
   mies_file_model pm (.mclk(mclk), .file_raddr(file_raddr), .file_wr(file_wr), .file_rdata(file_rdata));
   always #25 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic push(input logic [9:0] a);
      @(negedge mclk);
      stack_push = 1'b1;
      stack_push_addr = a;
      @(negedge mclk);
      stack_push = 1'b0;
      stk.push_back(a);
   endtask
   // The reference is updated before the word is offered, so the file is read after the last write landed.
   task automatic op(input logic [12:0] w);
      logic [7:0] r;
      logic [7:0] res;
      logic [8:0] s;
      logic [4:0] h;
      logic       cin;
      logic       ret;
      logic       slp;
      logic       unk;
      @(negedge mclk);
      r = (w[12:8] == `MIES_LIT_SUB) ? w[7:0] : pm.mem[w[5:0]];
      cin = (w[12:7] == `MIES_REG_SBC) ? ef.carry : 1'b1;
      s = {1'b0, r} + {1'b0, ~ew} + 9'(cin);
      h = {1'b0, r[3:0]} + {1'b0, ~ew[3:0]} + 5'(cin);
      res = ew;
      unk = 1'b0;
      case (w[12:7])
         `MIES_REG_RL: {ef.carry, res} = {r, ef.carry};
         `MIES_REG_RR: {res, ef.carry} = {ef.carry, r};
         `MIES_REG_SBC, `MIES_REG_SUB: {ef.carry, res, ef.half_carry_flag} = {s, h[4]};
         `MIES_REG_SWAP: res = {r[3:0], r[7:4]};
         `MIES_REG_XOR: res = ew ^ r;
         default:
         begin
            case (w[12:8])
               `MIES_LIT_RET: ew = w[7:0];
               `MIES_LIT_SUB: {ef.carry, ew, ef.half_carry_flag} = {s, h[4]};
               `MIES_LIT_XOR: ew = ew ^ w[7:0];
               default: unk = 1'b1;
            endcase
            if (w[12:8] inside {`MIES_LIT_SUB, `MIES_LIT_XOR})
               ef.zero = (ew == 8'h00);
         end
      endcase
      if (w[12:7] inside {`MIES_REG_SBC, `MIES_REG_SUB, `MIES_REG_XOR})
         ef.zero = (res == 8'h00);
      if (w[12:7] inside {[`MIES_REG_RL:`MIES_REG_XOR]} && !w[6])
         ew = res;
      case (w)
         `MIES_OP_IDLE, `MIES_OP_RETURN: unk = 1'b0;
         `MIES_OP_OPTION: {eo, unk} = {ew, 1'b0};
         `MIES_OP_SLEEP: {ef.watchdog_expiry_flag, ef.sleep_entry_flag, unk} = 3'b100;
         `MIES_OP_IRQ_RETURN: {ef.global_irq_enable, unk} = 2'b10;
         default: ;
      endcase
      slp = (w == `MIES_OP_SLEEP);
      ret = w inside {`MIES_OP_RETURN, `MIES_OP_IRQ_RETURN} || w[12:8] == `MIES_LIT_RET;
      ep = ret ? stk.pop_back() : ep + 10'h001;
      instr_valid = 1'b1;
      instr = w;
      while (instr_ready !== 1'b1)
         @(negedge mclk);
      @(negedge mclk);
      instr_valid = 1'b0;
      `CHK(pc, ep)
      `CHK(working_register, ew)
      `CHK(flags, ef)
      `CHK(option_setup, eo)
      `CHK(file_wr.we, w[12:7] inside {[`MIES_REG_RL:`MIES_REG_XOR]} && w[6])
      `CHK(file_raddr, w[5:0])
      if (file_wr.we === 1'b1)
         `CHK(file_wr, {1'b1, w[5:0], res})
      `CHK(instr_ready, !(ret || slp))
      `CHK(watchdog_clear, slp)
      `CHK(sleep_mode, slp)
      `CHK(unknown_op, unk)
   endtask
   initial
   begin
      repeat (4) @(negedge mclk);
      `CHK(pc, `MIES_PC_RST)
      `CHK(working_register, `MIES_WREG_RST)
      `CHK(option_setup, `MIES_OPTION_RST)
      `CHK(flags, ef)
      rst_b = 1'b1;
      push(10'h123);
      push(10'h2a0);
      push(10'h3ff);
      op({`MIES_LIT_XOR, 8'h5a});
      op({`MIES_LIT_XOR, 8'h5a});
      op({`MIES_LIT_XOR, 8'hc3});
      op(`MIES_OP_OPTION);
      op(`MIES_OP_IDLE);
      for (int k = 0; k < 24; k++)
         op({`MIES_REG_RL + 6'((k / 2) % 6), k[0], 6'(k * 5)});
      op({`MIES_LIT_SUB, ew});
      op({`MIES_LIT_SUB, 8'h00});
      op(13'h0001);
      op({`MIES_LIT_RET, 8'h7e});
      op(`MIES_OP_RETURN);
      op(`MIES_OP_IRQ_RETURN);
      op(`MIES_OP_SLEEP);
      @(negedge mclk);
      wake_req = 1'b1;
      @(negedge mclk);
      wake_req = 1'b0;
      `CHK(sleep_mode, 1'b0)
      `CHK(instr_ready, 1'b1)
      op(`MIES_OP_IDLE);
      summarize();
   end
endmodule
